// ---- hw/ucrs_pkg.sv ----
// package for the channel register select block: offsets, field positions, resets
// assumes a byte-wide parallel host bus with three address lines
package ucrs_pkg;
    // register offsets on the three address lines
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_IEN = 3'h1;
    localparam logic [2:0] OFF_IID = 3'h2;
    localparam logic [2:0] OFF_LFC = 3'h3;
    localparam logic [2:0] OFF_MLC = 3'h4;
    localparam logic [2:0] OFF_LST = 3'h5;
    localparam logic [2:0] OFF_MST = 3'h6;
    localparam logic [2:0] OFF_SCR = 3'h7;
    // magic line format value opening the enhanced bank
    localparam logic [7:0] LFC_ENH_KEY = 8'hBF;
    // field positions
    localparam int LFC_DIV_BIT = 7;
    localparam int EF_ENABLE_BIT = 4;
    localparam int MLC_PRESCALE_BIT = 7;
    localparam int MLC_TCRTLR_BIT = 6;
    localparam int MLC_LOOP_BIT = 4;
    localparam int MLC_RDY_BIT = 2;
    // masks of bits writable only with enhanced functions on
    localparam logic [7:0] IEN_ENH_MASK = 8'hF0;
    localparam logic [7:0] FCTL_ENH_MASK = 8'h30;
    localparam logic [7:0] MLC_ENH_MASK = 8'h80;
    // values after reset
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] LFC_RESET = 8'h1D;
    // decoded register targets
    typedef enum logic [4:0] {
        UCRS_NONE, UCRS_HOLD, UCRS_IEN, UCRS_IID, UCRS_LFC, UCRS_MLC, UCRS_LST,
        UCRS_MST, UCRS_SCR, UCRS_DLL, UCRS_DLH, UCRS_EF, UCRS_RES1, UCRS_RES2,
        UCRS_PAU1, UCRS_PAU2, UCRS_TCR, UCRS_TLR, UCRS_RDY
    } ucrs_sel_t;
endpackage

// ---- hw/ucrs_strobe_sync.sv ----
// two-flop synchroniser with edge pulses for an active-low host strobe
// assumes strobe comes straight from a pin, asynchronous to sys_clk
`timescale 1ns/1ps
module ucrs_strobe_sync (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic strobe_n,
    output logic active,
    output logic start_pulse,
    output logic end_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // first flop only feeds the second; edges come from the later stages
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= ~strobe_n;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign active = sync_reg;
    assign start_pulse = sync_reg & ~prev_reg;
    assign end_pulse = ~sync_reg & prev_reg;
endmodule // ucrs_strobe_sync

// ---- hw/ucrs_channel_regs.sv ----
// register selection and access gating for one serial channel
// assumes host holds address and data stable while a strobe is low
//
// Contract
// - register chosen from three address lines plus selection bits; host drives all lines.
// - offset 0 reads received character, writes transmit character when divisor bit clear.
// - offset 2 reads interrupt identification, writes write-only fifo control.
// - offsets 5 and 6 read line and modem status; writes there ignored.
// - offsets 1, 3, 4, 7 hold interrupt enable, line format, modem control, scratch.
// - divisor bit set maps offsets 0 and 1 to divisor low and high bytes.
// - line format 0xBF maps offset 2 to enhanced feature, 4..7 to flow characters.
// - offsets 6 and 7 reach threshold and trigger registers when enable bits set.
// - offset 7 reads all-channel fifo ready when selected, ready-enable set, no loopback.
// - prescale bit of modem control changes only with enhanced functions enabled.
// - enhanced interrupt enable and transmit trigger bits frozen while enhancement off.
`timescale 1ns/1ps
module ucrs_channel_regs (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] addr,
    input wire logic cs_n,
    input wire logic any_cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire logic [7:0] receive_holding,
    input wire logic [7:0] interrupt_identification,
    input wire logic [7:0] line_state,
    input wire logic [7:0] modem_line_state,
    input wire logic [7:0] all_channel_fifo_ready,
    output logic rx_pop,
    output logic [7:0] transmit_holding,
    output logic tx_push,
    output logic [7:0] fifo_control,
    output logic fifo_control_wr,
    output logic [7:0] interrupt_enable_reg,
    output logic [7:0] line_format_control,
    output logic [7:0] modem_line_control,
    output logic [15:0] baud_divisor,
    output logic [7:0] enhanced_feature,
    output logic [7:0] resume_char_1,
    output logic [7:0] resume_char_2,
    output logic [7:0] pause_char_1,
    output logic [7:0] pause_char_2,
    output logic [7:0] flow_threshold_control,
    output logic [7:0] fifo_trigger_level
);
    logic rd_act, rd_start, rd_end;
    logic wr_act, wr_start, wr_end;
    logic [2:0] addr_m_reg, addr_s_reg;
    logic cs_m_reg, cs_s_reg, anycs_m_reg, anycs_s_reg;
    logic [7:0] din_m_reg, din_s_reg;
    logic [7:0] ien_reg, lfc_reg, mlc_reg, dll_reg, dlh_reg, ef_reg;
    logic [7:0] res1_reg, res2_reg, pau1_reg, pau2_reg, tcr_reg, tlr_reg, scr_reg;
    logic [7:0] fctl_reg, thr_reg, dout_reg;
    logic oe_n_reg, push_reg, pop_reg, fwr_reg;
    logic [7:0] dout_next;
    // decoded targets for the two directions, recomputed every cycle
    ucrs_pkg::ucrs_sel_t rd_sel, wr_sel;
    logic enh_on;

    // strobes arrive from pins and cross through two flops each
    // the two strobes are synchronised apart; a host never drives both at once
    ucrs_strobe_sync u_rd_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .strobe_n(rd_n),
        .active(rd_act),
        .start_pulse(rd_start),
        .end_pulse(rd_end)
    );
    ucrs_strobe_sync u_wr_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .strobe_n(wr_n),
        .active(wr_act),
        .start_pulse(wr_start),
        .end_pulse(wr_end)
    );

    // address, selects and data pins pass two flops as well
    // limitation: pins must settle before the strobe; late changes are not caught
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            addr_m_reg <= 3'h0;
            addr_s_reg <= 3'h0;
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            anycs_m_reg <= 1'b1;
            anycs_s_reg <= 1'b1;
            din_m_reg <= 8'h00;
            din_s_reg <= 8'h00;
        end else begin
            addr_m_reg <= addr;
            addr_s_reg <= addr_m_reg;
            cs_m_reg <= cs_n;
            cs_s_reg <= cs_m_reg;
            anycs_m_reg <= any_cs_n;
            anycs_s_reg <= anycs_m_reg;
            din_m_reg <= data_in;
            din_s_reg <= din_m_reg;
        end
    end

    // enhancement gate, read by the decoder and by the guarded registers
    assign enh_on = ef_reg[ucrs_pkg::EF_ENABLE_BIT];

    // one decoder for both directions; write side drops read-only targets
    function automatic ucrs_pkg::ucrs_sel_t decode(input logic [2:0] a, input logic is_wr);
        logic key, divisor_access_bit, tt, rdy;
        ucrs_pkg::ucrs_sel_t s;
        key = (lfc_reg == ucrs_pkg::LFC_ENH_KEY);
        divisor_access_bit = lfc_reg[ucrs_pkg::LFC_DIV_BIT];
        tt = enh_on & mlc_reg[ucrs_pkg::MLC_TCRTLR_BIT];
        rdy = ~anycs_s_reg & mlc_reg[ucrs_pkg::MLC_RDY_BIT]
            & ~mlc_reg[ucrs_pkg::MLC_LOOP_BIT];
        s = ucrs_pkg::UCRS_NONE;
        // the key value also sets the divisor bit: offsets 0 and 1 reach the divisor then
        case (a)
            ucrs_pkg::OFF_DATA: s = divisor_access_bit ? ucrs_pkg::UCRS_DLL : ucrs_pkg::UCRS_HOLD;
            ucrs_pkg::OFF_IEN: s = divisor_access_bit ? ucrs_pkg::UCRS_DLH : ucrs_pkg::UCRS_IEN;
            ucrs_pkg::OFF_IID: s = key ? ucrs_pkg::UCRS_EF : ucrs_pkg::UCRS_IID;
            ucrs_pkg::OFF_LFC: s = ucrs_pkg::UCRS_LFC;
            ucrs_pkg::OFF_MLC: s = key ? ucrs_pkg::UCRS_RES1 : ucrs_pkg::UCRS_MLC;
            ucrs_pkg::OFF_LST: s = key ? ucrs_pkg::UCRS_RES2 : ucrs_pkg::UCRS_LST;
            // upper offsets: key bank first, then threshold and trigger, then the rest
            ucrs_pkg::OFF_MST: begin
                if (key) s = ucrs_pkg::UCRS_PAU1;
                else if (tt) s = ucrs_pkg::UCRS_TCR;
                else s = ucrs_pkg::UCRS_MST;
            end
            ucrs_pkg::OFF_SCR: begin
                if (key) s = ucrs_pkg::UCRS_PAU2;
                else if (tt) s = ucrs_pkg::UCRS_TLR;
                else if (rdy && !is_wr) s = ucrs_pkg::UCRS_RDY;
                else s = ucrs_pkg::UCRS_SCR;
            end
            default: s = ucrs_pkg::UCRS_NONE;
        endcase
        // status targets have no write side
        if (is_wr && (s == ucrs_pkg::UCRS_LST || s == ucrs_pkg::UCRS_MST))
            s = ucrs_pkg::UCRS_NONE;
        return s;
    endfunction

    // a process rather than an assign: the decoder also reads the selection
    // registers, and a change of those alone must re-run it
    always_comb begin
        rd_sel = decode(addr_s_reg, 1'b0);
        wr_sel = decode(addr_s_reg, 1'b1);
    end

    // read mux, sampled at strobe start
    // unmapped targets read as zero, never as a stale byte
    always_comb begin
        dout_next = 8'h00;
        case (rd_sel)
            ucrs_pkg::UCRS_HOLD: dout_next = receive_holding;
            ucrs_pkg::UCRS_IEN: dout_next = ien_reg;
            ucrs_pkg::UCRS_IID: dout_next = interrupt_identification;
            ucrs_pkg::UCRS_LFC: dout_next = lfc_reg;
            ucrs_pkg::UCRS_MLC: dout_next = mlc_reg;
            ucrs_pkg::UCRS_LST: dout_next = line_state;
            ucrs_pkg::UCRS_MST: dout_next = modem_line_state;
            ucrs_pkg::UCRS_SCR: dout_next = scr_reg;
            ucrs_pkg::UCRS_DLL: dout_next = dll_reg;
            ucrs_pkg::UCRS_DLH: dout_next = dlh_reg;
            ucrs_pkg::UCRS_EF: dout_next = ef_reg;
            ucrs_pkg::UCRS_RES1: dout_next = res1_reg;
            ucrs_pkg::UCRS_RES2: dout_next = res2_reg;
            ucrs_pkg::UCRS_PAU1: dout_next = pau1_reg;
            ucrs_pkg::UCRS_PAU2: dout_next = pau2_reg;
            ucrs_pkg::UCRS_TCR: dout_next = tcr_reg;
            ucrs_pkg::UCRS_TLR: dout_next = tlr_reg;
            ucrs_pkg::UCRS_RDY: dout_next = all_channel_fifo_ready;
            default: dout_next = 8'h00;
        endcase
    end

    // read data drive: latched at strobe start, held until strobe ends
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout_reg <= 8'h00;
            oe_n_reg <= 1'b1;
            pop_reg <= 1'b0;
        end else begin
            pop_reg <= 1'b0;
            // drive drops when the strobe ends, even if the select went first
            if (rd_start && !cs_s_reg) begin
                dout_reg <= dout_next;
                oe_n_reg <= 1'b0;
            end else if (rd_end || !rd_act) begin
                oe_n_reg <= 1'b1;
            end
            // character consumed when the read finishes, not when it starts
            if (rd_end && !oe_n_reg && rd_sel == ucrs_pkg::UCRS_HOLD)
                pop_reg <= 1'b1;
        end
    end

    // write commit: one pulse at strobe start while selected
    // a strobe seen while deselected belongs to another channel and is ignored
    logic wr_go;
    assign wr_go = wr_start & ~cs_s_reg;

    // plain configuration registers
    // line format resets to a value outside the key bank
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lfc_reg <= ucrs_pkg::LFC_RESET;
            dll_reg <= ucrs_pkg::REG_RESET;
            dlh_reg <= ucrs_pkg::REG_RESET;
            ef_reg <= ucrs_pkg::REG_RESET;
            scr_reg <= ucrs_pkg::REG_RESET;
            res1_reg <= ucrs_pkg::REG_RESET;
            res2_reg <= ucrs_pkg::REG_RESET;
            pau1_reg <= ucrs_pkg::REG_RESET;
            pau2_reg <= ucrs_pkg::REG_RESET;
            tcr_reg <= ucrs_pkg::REG_RESET;
            tlr_reg <= ucrs_pkg::REG_RESET;
        end else if (wr_go) begin
            case (wr_sel)
                ucrs_pkg::UCRS_LFC: lfc_reg <= din_s_reg;
                ucrs_pkg::UCRS_SCR: scr_reg <= din_s_reg;
                ucrs_pkg::UCRS_DLL: dll_reg <= din_s_reg;
                ucrs_pkg::UCRS_DLH: dlh_reg <= din_s_reg;
                ucrs_pkg::UCRS_EF: ef_reg <= din_s_reg;
                ucrs_pkg::UCRS_RES1: res1_reg <= din_s_reg;
                ucrs_pkg::UCRS_RES2: res2_reg <= din_s_reg;
                ucrs_pkg::UCRS_PAU1: pau1_reg <= din_s_reg;
                ucrs_pkg::UCRS_PAU2: pau2_reg <= din_s_reg;
                ucrs_pkg::UCRS_TCR: tcr_reg <= din_s_reg;
                ucrs_pkg::UCRS_TLR: tlr_reg <= din_s_reg;
                default: ;
            endcase
        end
    end

    // guarded registers: enhanced bits keep their value unless enabled
    // masking keeps a plain write usable without turning enhancement on
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ien_reg <= ucrs_pkg::REG_RESET;
            mlc_reg <= ucrs_pkg::REG_RESET;
            fctl_reg <= ucrs_pkg::REG_RESET;
        end else if (wr_go) begin
            case (wr_sel)
                ucrs_pkg::UCRS_IEN:
                    ien_reg <= enh_on ? din_s_reg
                        : ((ien_reg & ucrs_pkg::IEN_ENH_MASK)
                        | (din_s_reg & ~ucrs_pkg::IEN_ENH_MASK));
                ucrs_pkg::UCRS_MLC:
                    mlc_reg <= enh_on ? din_s_reg
                        : ((mlc_reg & ucrs_pkg::MLC_ENH_MASK)
                        | (din_s_reg & ~ucrs_pkg::MLC_ENH_MASK));
                ucrs_pkg::UCRS_IID:
                    fctl_reg <= enh_on ? din_s_reg
                        : ((fctl_reg & ucrs_pkg::FCTL_ENH_MASK)
                        | (din_s_reg & ~ucrs_pkg::FCTL_ENH_MASK));
                default: ;
            endcase
        end
    end

    // datapath strobes toward the fifos
    // push and held byte change at one edge so the fifo sees both together
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            thr_reg <= 8'h00;
            push_reg <= 1'b0;
            fwr_reg <= 1'b0;
        end else begin
            push_reg <= wr_go && (wr_sel == ucrs_pkg::UCRS_HOLD);
            fwr_reg <= wr_go && (wr_sel == ucrs_pkg::UCRS_IID);
            if (wr_go && wr_sel == ucrs_pkg::UCRS_HOLD)
                thr_reg <= din_s_reg;
        end
    end

    // all outputs come from flops
    assign data_out = dout_reg;
    assign data_oe_n = oe_n_reg;
    assign rx_pop = pop_reg;
    assign transmit_holding = thr_reg;
    assign tx_push = push_reg;
    assign fifo_control = fctl_reg;
    assign fifo_control_wr = fwr_reg;
    assign interrupt_enable_reg = ien_reg;
    assign line_format_control = lfc_reg;
    assign modem_line_control = mlc_reg;
    assign baud_divisor = {dlh_reg, dll_reg};
    assign enhanced_feature = ef_reg;
    assign resume_char_1 = res1_reg;
    assign resume_char_2 = res2_reg;
    assign pause_char_1 = pau1_reg;
    assign pause_char_2 = pau2_reg;
    assign flow_threshold_control = tcr_reg;
    assign fifo_trigger_level = tlr_reg;
endmodule // ucrs_channel_regs

// ---- dv/ucrs_host_model.sv ----
// host processor model driving the channel's parallel register bus
// assumes the bench calls access() while sys_clk runs; strobes move on falling edges
`timescale 1ns/1ps
module ucrs_host_model (
    input wire logic sys_clk,
    output logic [2:0] addr,
    output logic cs_n,
    output logic any_cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] data_in
);
    // idle bus: nothing selected, no strobe
    initial begin
        addr = 3'h0;
        cs_n = 1'b1;
        any_cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data_in = 8'hA5;
    end

    // one access: address settles 3 clocks before the strobe, strobe 6 low, long idle after
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr <= a;
        data_in <= d;
        cs_n <= 1'b0;
        any_cs_n <= 1'b0;
        repeat (3) @(negedge sys_clk);
        if (wr) begin
            wr_n <= 1'b0;
        end else begin
            rd_n <= 1'b0;
        end
        repeat (6) @(negedge sys_clk);
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        // select held past the synced strobe release so read drive ends cleanly
        repeat (5) @(negedge sys_clk);
        cs_n <= 1'b1;
        any_cs_n <= 1'b1;
        data_in <= ~d; // released bus shows no stale byte
        repeat (2) @(negedge sys_clk);
    endtask
endmodule // ucrs_host_model

// ---- dv/ucrs_chk_monitor.sv ----
// concurrent checks on the channel register select block's ports
// assumes a bind into ucrs_channel_regs; one clock, async active-low reset
`timescale 1ns/1ps
module ucrs_chk_monitor (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] addr,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    input wire logic data_oe_n,
    input wire logic tx_push,
    input wire logic [7:0] transmit_holding,
    input wire logic fifo_control_wr,
    input wire logic [7:0] fifo_control,
    input wire logic [7:0] interrupt_enable_reg,
    input wire logic [7:0] line_format_control,
    input wire logic [7:0] modem_line_control,
    input wire logic [7:0] enhanced_feature,
    input wire logic rx_pop,
    input wire logic [15:0] baud_divisor
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // read drive tracks the strobe within the sync latency
    read_drive_a: assert property ($fell(rd_n) && !cs_n |-> ##[2:4] !data_oe_n)
        else $error("read data not driven after read strobe");
    read_release_a: assert property ($rose(rd_n) |-> ##[2:4] data_oe_n)
        else $error("read data still driven after strobe release");
    drive_cause_a: assert property (!data_oe_n |-> !cs_n)
        else $error("read data driven while channel not selected");
    // transmit push is a single pulse from a normal-bank data write
    tx_pulse_a: assert property (tx_push |=> !tx_push)
        else $error("transmit push longer than one cycle");
    tx_cause_a: assert property (tx_push |-> !wr_n && addr == ucrs_pkg::OFF_DATA
        && transmit_holding == data_in && !line_format_control[ucrs_pkg::LFC_DIV_BIT])
        else $error("transmit push without matching data write");
    fctl_cause_a: assert property (fifo_control_wr |-> !wr_n
        && addr == ucrs_pkg::OFF_IID && line_format_control != ucrs_pkg::LFC_ENH_KEY)
        else $error("fifo control written without matching write");
    // enhanced bits frozen while enhanced functions are off
    ien_freeze_a: assert property (!enhanced_feature[ucrs_pkg::EF_ENABLE_BIT]
        |=> $stable(interrupt_enable_reg[7:4]))
        else $error("enhanced interrupt enable bits changed");
    fctl_freeze_a: assert property (!enhanced_feature[ucrs_pkg::EF_ENABLE_BIT]
        |=> $stable(fifo_control[5:4]))
        else $error("transmit trigger bits changed");
    prescale_freeze_a: assert property (!enhanced_feature[ucrs_pkg::EF_ENABLE_BIT]
        |=> $stable(modem_line_control[ucrs_pkg::MLC_PRESCALE_BIT]))
        else $error("prescale bit changed");
    // writes at the status offset land nowhere outside the key bank
    status_write_a: assert property (!wr_n && addr == ucrs_pkg::OFF_LST |=>
        $stable({interrupt_enable_reg, line_format_control, modem_line_control, fifo_control}))
        else $error("status offset write changed a register");
    // receive pop is one pulse, after a normal-bank data read has ended
    pop_pulse_a: assert property (rx_pop |=> !rx_pop)
        else $error("receive pop longer than one cycle");
    pop_cause_a: assert property (rx_pop |-> rd_n && !cs_n
        && addr == ucrs_pkg::OFF_DATA && !line_format_control[ucrs_pkg::LFC_DIV_BIT])
        else $error("receive pop without matching data read");
    // divisor bytes move only under a write with the divisor bit set
    divisor_write_a: assert property (!$stable(baud_divisor) |-> !wr_n
        && line_format_control[ucrs_pkg::LFC_DIV_BIT])
        else $error("divisor changed without a divisor write");

    cover property (tx_push);
    cover property (fifo_control_wr);
    cover property (rx_pop);
    cover property ($fell(data_oe_n) && addr == ucrs_pkg::OFF_SCR);
endmodule // ucrs_chk_monitor

bind ucrs_channel_regs ucrs_chk_monitor chk (.sys_clk, .nrst, .addr, .cs_n, .rd_n, .wr_n,
    .data_in, .data_oe_n, .tx_push, .transmit_holding, .fifo_control_wr, .fifo_control,
    .interrupt_enable_reg, .line_format_control, .modem_line_control, .enhanced_feature,
    .rx_pop, .baud_divisor);

// ---- dv/uart_channel_register_select_bench.sv ----
// self-checking bench for the channel register select block
// assumes the host model drives the bus; results are checked against a queue of notes
`timescale 1ns/1ps
`define CMP(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module uart_channel_register_select_bench;
    logic sys_clk, nrst, cs_n, any_cs_n, rd_n, wr_n, data_oe_n, tx_push, fifo_control_wr;
    logic [2:0] addr;
    logic [7:0] data_in, data_out, transmit_holding, fifo_control, rx_char, iid, lst, mst, rdy;
    logic [7:0] exp_q[$];
    int fail_count = 0;
    int n_tests = 0;

    ucrs_host_model host (.sys_clk(sys_clk), .addr(addr), .cs_n(cs_n), .any_cs_n(any_cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));

    ucrs_channel_regs uut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .cs_n(cs_n),
        .any_cs_n(any_cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .receive_holding(rx_char), .interrupt_identification(iid),
        .line_state(lst), .modem_line_state(mst), .all_channel_fifo_ready(rdy), .rx_pop(),
        .transmit_holding(transmit_holding), .tx_push(tx_push), .fifo_control(fifo_control),
        .fifo_control_wr(fifo_control_wr), .interrupt_enable_reg(), .line_format_control(),
        .modem_line_control(), .baud_divisor(), .enhanced_feature(), .resume_char_1(),
        .resume_char_2(), .pause_char_1(), .pause_char_2(), .flow_threshold_control(),
        .fifo_trigger_level());

    always #5 sys_clk = ~sys_clk;

    // one bus access; a result the access will produce is noted first
    task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d,
            input logic [7:0] e, input bit note);
        if (note) exp_q.push_back(e);
        host.access(w, a, d);
    endtask

    // oldest note against whatever result just appeared
    task automatic take(input logic [7:0] got);
        logic [7:0] e;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
        `CMP(got, e)
    endtask

    // watcher: read drive, transmit push and fifo control write are the results
    always @(negedge data_oe_n) begin
        #1;
        take(data_out);
    end
    always @(posedge sys_clk) begin
        #1;
        if (tx_push === 1'b1) take(transmit_holding);
        if (fifo_control_wr === 1'b1) take(fifo_control);
    end

    task automatic wrap_up;
        fail_count += exp_q.size(); // notes never matched by a result
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog: about four times the expected run length
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        wrap_up;
    end

    initial begin
        logic [7:0] r;
        r = 8'($urandom(32'hCE7B));
        sys_clk = 1'b0;
        nrst = 1'b0;
        r = 8'($urandom);
        {rx_char, iid, lst, mst} = $urandom;
        rdy = 8'($urandom);
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        op(0, 3'h3, 8'h00, ucrs_pkg::LFC_RESET, 1);
        op(1, 3'h1, 8'hFF, 8'h00, 0);
        op(0, 3'h1, 8'h00, 8'h0F, 1);
        op(1, 3'h7, r, 8'h00, 0);
        op(1, 3'h5, ~r, 8'h00, 0);
        op(1, 3'h6, ~r, 8'h00, 0);
        op(0, 3'h7, 8'h00, r, 1);
        op(1, 3'h0, r + 8'h01, r + 8'h01, 1);
        op(0, 3'h0, 8'h00, rx_char, 1);
        op(0, 3'h2, 8'h00, iid, 1);
        op(1, 3'h2, 8'hFF, 8'hCF, 1);
        op(0, 3'h5, 8'h00, lst, 1);
        op(0, 3'h6, 8'h00, mst, 1);
        op(1, 3'h4, 8'h80, 8'h00, 0);
        op(0, 3'h4, 8'h00, 8'h00, 1);
        op(1, 3'h3, 8'h80, 8'h00, 0);
        op(1, 3'h0, r, 8'h00, 0);
        op(1, 3'h1, ~r, 8'h00, 0);
        op(0, 3'h0, 8'h00, r, 1);
        op(0, 3'h1, 8'h00, ~r, 1);
        op(1, 3'h3, ucrs_pkg::LFC_ENH_KEY, 8'h00, 0);
        op(1, 3'h2, 8'h10, 8'h00, 0);
        for (int i = 4; i < 8; i++) op(1, 3'(i), r ^ 8'(i), 8'h00, 0);
        for (int i = 4; i < 8; i++) op(0, 3'(i), 8'h00, r ^ 8'(i), 1);
        op(0, 3'h2, 8'h00, 8'h10, 1);
        op(1, 3'h3, 8'h03, 8'h00, 0);
        op(1, 3'h4, 8'hC0, 8'h00, 0);
        op(0, 3'h4, 8'h00, 8'hC0, 1);
        op(1, 3'h6, r, 8'h00, 0);
        op(1, 3'h7, ~r, 8'h00, 0);
        op(0, 3'h6, 8'h00, r, 1);
        op(0, 3'h7, 8'h00, ~r, 1);
        op(1, 3'h4, 8'h04, 8'h00, 0);
        op(0, 3'h7, 8'h00, rdy, 1);
        op(1, 3'h1, 8'hFF, 8'h00, 0);
        op(0, 3'h1, 8'h00, 8'hFF, 1);
        op(1, 3'h2, 8'h30, 8'h30, 1);
        repeat (5) @(negedge sys_clk);
        wrap_up;
    end
endmodule // uart_channel_register_select_bench
